// ---- verilog/tracker_pkg.sv ----
/*
  constants, field layout, command and format codes and state encoding
  shared by the extreme/latest tracker, its host model and its bench.
  assumes nothing of its surroundings.
*/
package tracker_pkg;
  localparam int DATA_W = 16;
  localparam int TS_W   = 32;
  localparam int NCH    = 16;
  localparam int CH_W   = 4;

  // stored record layout, latest reading in the low bits
  localparam int LAST_LSB  = 0;
  localparam int MINTS_LSB = LAST_LSB + DATA_W;
  localparam int MIN_LSB   = MINTS_LSB + TS_W;
  localparam int MAXTS_LSB = MIN_LSB + DATA_W;
  localparam int MAX_LSB   = MAXTS_LSB + TS_W;
  localparam int REC_W     = MAX_LSB + DATA_W;

  // host query codes
  localparam logic [1:0] CMD_READ_ALL   = 2'h0;
  localparam logic [1:0] CMD_READ_RESET = 2'h1;
  localparam logic [1:0] CMD_LATEST_ALL = 2'h2;
  localparam logic [1:0] CMD_LATEST_SEL = 2'h3;

  // output format codes
  localparam logic [1:0] FMT_ENG     = 2'h0;
  localparam logic [1:0] FMT_BIN_LH  = 2'h1;
  localparam logic [1:0] FMT_BIN_HL  = 2'h2;
  localparam logic [1:0] FMT_COUNTS  = 2'h3;

  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_UPD   = 3'b001,
    ST_QSCAN = 3'b010,
    ST_QEMIT = 3'b011,
    ST_QDONE = 3'b100
  } state_e;
endpackage : tracker_pkg

// ---- verilog/record_store.sv ----
/*
  per-channel record memory: one write port, one read port with
  registered read data.
  assumes a single clock and that the caller resolves read/write hazards.
*/
`timescale 1ns/10ps
module record_store #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic          mclk,
  // write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  // read port
  input  wire logic [AW-1:0] rdAddr,
  output logic      [W-1:0]  rdData
);
  logic [W-1:0] mem [DEPTH];

  // contents are undefined until a channel's valid bit is set upstream
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : record_store

// ---- verilog/channel_high_low_last_tracker.sv ----
/*
  extreme_latest_store: per-channel maximum, minimum (with stamps) and
  latest reading, updated from the scan stream and read out by host query.
  assumes scan order equals ascending channel number, and that the time
  input carries the running clock/date stamp.
*/
`timescale 1ns/10ps
module channel_high_low_last_tracker
  import tracker_pkg::*;
#(
  parameter int NUM_CH = tracker_pkg::NCH
) (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  // configuration and acquisition control
  input  wire logic [tracker_pkg::NCH-1:0]    cfgMask,
  input  wire logic                           cfgLoad,
  input  wire logic                           acqRun,
  input  wire logic [1:0]                     fmtCode,
  input  wire logic                           termEnable,
  input  wire logic [tracker_pkg::TS_W-1:0]   timeStamp,
  // scan stream
  input  wire logic                           scanValid,
  input  wire logic [tracker_pkg::CH_W-1:0]   scanChan,
  input  wire logic [tracker_pkg::DATA_W-1:0] scanData,
  output logic                                scanReadyFf,
  // query request
  input  wire logic                           qValid,
  input  wire logic [1:0]                     qCmd,
  input  wire logic [tracker_pkg::CH_W-1:0]   qLo,
  input  wire logic [tracker_pkg::CH_W-1:0]   qHi,
  output logic                                qAckFf,
  // reply stream
  output logic                                recValidFf,
  output logic [tracker_pkg::CH_W-1:0]        recChanFf,
  output logic [tracker_pkg::DATA_W-1:0]      recMaxFf,
  output logic [tracker_pkg::TS_W-1:0]        maximum_timestampFf,
  output logic [tracker_pkg::DATA_W-1:0]      recMinFf,
  output logic [tracker_pkg::TS_W-1:0]        minimum_timestampFf,
  output logic [tracker_pkg::DATA_W-1:0]      recLastFf,
  output logic                                recOnlyLastFf,
  output logic                                recTermFf,
  output logic [1:0]                          recFormatFf,
  output logic                                respDoneFf
);
  localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);

  logic [1:0] rstSyncFf;
  logic       rstN;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSyncFf <= RST_SYNC_INIT;
    end else begin
      rstSyncFf <= {rstSyncFf[0], 1'b1};
    end
  end
  assign rstN = rstSyncFf[1];

  function automatic logic [DATA_W-1:0] encode(input logic [DATA_W-1:0] d,
                                               input logic [1:0] f);
    // unit scaling lives upstream; only the byte order differs here
    encode = (f == FMT_BIN_HL) ? {d[7:0], d[DATA_W-1:8]} : d;
  endfunction : encode

  state_e              stateFf, nxt_state;
  logic [NCH-1:0]      hasDataFf, nxt_hasData;
  logic [CH_W-1:0]     smpChanFf, nxt_smpChan;
  logic [DATA_W-1:0]   smpDataFf, nxt_smpData;
  logic [TS_W-1:0]     smpTsFf, nxt_smpTs;
  logic [CH_W-1:0]     chIdxFf, nxt_chIdx;
  logic [1:0]          cmdFf, nxt_cmd;
  logic [CH_W-1:0]     loFf, nxt_lo, hiFf, nxt_hi;
  logic [NCH-1:0]      cfgHoldFf, nxt_cfgHold;
  logic [1:0]          fmtHoldFf, nxt_fmtHold;
  logic                termHoldFf, nxt_termHold;
  logic                nxt_scanReady, nxt_qAck, nxt_recValid, nxt_recOnlyLast;
  logic                nxt_recTerm, nxt_respDone;
  logic [CH_W-1:0]     nxt_recChan;
  logic [DATA_W-1:0]   nxt_recMax, nxt_recMin, nxt_recLast;
  logic [TS_W-1:0]     nxt_maxTs, nxt_minTs;
  logic [1:0]          nxt_recFormat;

  logic                wrEn;
  logic [CH_W-1:0]     wrAddr, rdAddr;
  logic [REC_W-1:0]    wrData, rdData;
  logic signed [DATA_W-1:0] oldMax, oldMin, newD;
  logic                eligible;
  logic                scanTake;

  record_store #(.W(REC_W), .DEPTH(NCH), .AW(CH_W)) u_store (
    .mclk   (mclk),
    .wrEn   (wrEn),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .rdAddr (rdAddr),
    .rdData (rdData)
  );

  assign oldMax   = rdData[MAX_LSB +: DATA_W];
  assign oldMin   = rdData[MIN_LSB +: DATA_W];
  assign newD     = smpDataFf;
  assign scanTake = scanValid && scanReadyFf;
  // channel walk skips what is not configured or, for CMD_LATEST_SEL, outside the range
  assign eligible = cfgHoldFf[chIdxFf] &&
                    ((cmdFf != CMD_LATEST_SEL) ||
                     ((chIdxFf >= loFf) && (chIdxFf <= hiFf)));

  always_comb begin
    nxt_state       = stateFf;
    nxt_hasData     = cfgLoad ? '0 : hasDataFf;
    nxt_smpChan     = smpChanFf;
    nxt_smpData     = smpDataFf;
    nxt_smpTs       = smpTsFf;
    nxt_chIdx       = chIdxFf;
    nxt_cmd         = cmdFf;
    nxt_lo          = loFf;
    nxt_hi          = hiFf;
    nxt_cfgHold     = cfgHoldFf;
    nxt_fmtHold     = fmtHoldFf;
    nxt_termHold    = termHoldFf;
    nxt_qAck        = 1'b0;
    nxt_recValid    = 1'b0;
    nxt_respDone    = 1'b0;
    nxt_recChan     = recChanFf;
    nxt_recMax      = recMaxFf;
    nxt_maxTs       = maximum_timestampFf;
    nxt_recMin      = recMinFf;
    nxt_minTs       = minimum_timestampFf;
    nxt_recLast     = recLastFf;
    nxt_recOnlyLast = recOnlyLastFf;
    nxt_recTerm     = recTermFf;
    nxt_recFormat   = recFormatFf;
    wrEn            = 1'b0;
    wrAddr          = smpChanFf;
    wrData          = rdData;
    rdAddr          = chIdxFf;
    unique case (stateFf)
      ST_IDLE: begin
        if (scanTake) begin
          // scans outside a run or on idle channels are swallowed
          if (acqRun && cfgMask[scanChan]) begin
            nxt_smpChan = scanChan;
            nxt_smpData = scanData;
            nxt_smpTs   = timeStamp;
            rdAddr      = scanChan;
            nxt_state   = ST_UPD;
          end
        end else if (qValid) begin
          // the query reads this store (a read-reset also rewrites it), never the acquisition buffer
          nxt_qAck     = 1'b1;
          nxt_cmd      = qCmd;
          nxt_lo       = qLo;
          nxt_hi       = qHi;
          nxt_cfgHold  = cfgMask;
          nxt_fmtHold  = fmtCode;
          nxt_termHold = termEnable;
          nxt_chIdx    = '0;
          nxt_state    = ST_QSCAN;
        end
      end
      ST_UPD: begin
        wrEn = 1'b1;
        wrData[LAST_LSB +: DATA_W] = smpDataFf;
        if (!hasDataFf[smpChanFf]) begin
          wrData[MAX_LSB +: DATA_W] = smpDataFf;
          wrData[MAXTS_LSB +: TS_W] = smpTsFf;
          wrData[MIN_LSB +: DATA_W] = smpDataFf;
          wrData[MINTS_LSB +: TS_W] = smpTsFf;
        end else begin
          if (newD > oldMax) begin
            wrData[MAX_LSB +: DATA_W] = smpDataFf;
            wrData[MAXTS_LSB +: TS_W] = smpTsFf;
          end
          if (newD < oldMin) begin
            wrData[MIN_LSB +: DATA_W] = smpDataFf;
            wrData[MINTS_LSB +: TS_W] = smpTsFf;
          end
        end
        // set wins over a same-cycle configuration clear
        nxt_hasData[smpChanFf] = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_QSCAN: begin
        rdAddr = chIdxFf;
        if (eligible) begin
          nxt_state = ST_QEMIT;
        end else if (chIdxFf == LAST_CH) begin
          nxt_state = ST_QDONE;
        end else begin
          nxt_chIdx = chIdxFf + CH_W'(1);
        end
      end
      ST_QEMIT: begin
        nxt_recValid    = 1'b1;
        nxt_recChan     = chIdxFf;
        nxt_recOnlyLast = (cmdFf == CMD_LATEST_ALL) || (cmdFf == CMD_LATEST_SEL);
        nxt_recTerm     = termHoldFf;
        nxt_recFormat   = fmtHoldFf;
        nxt_recLast     = encode(rdData[LAST_LSB +: DATA_W], fmtHoldFf);
        if (nxt_recOnlyLast || !hasDataFf[chIdxFf]) begin
          nxt_recMax = '0;
          nxt_maxTs  = '0;
          nxt_recMin = '0;
          nxt_minTs  = '0;
        end else begin
          nxt_recMax = encode(rdData[MAX_LSB +: DATA_W], fmtHoldFf);
          nxt_maxTs  = rdData[MAXTS_LSB +: TS_W];
          nxt_recMin = encode(rdData[MIN_LSB +: DATA_W], fmtHoldFf);
          nxt_minTs  = rdData[MINTS_LSB +: TS_W];
        end
        if (cmdFf == CMD_READ_RESET && hasDataFf[chIdxFf]) begin
          // record already captured above, so the reply shows the old extremes
          wrEn   = 1'b1;
          wrAddr = chIdxFf;
          wrData[MAX_LSB +: DATA_W] = rdData[LAST_LSB +: DATA_W];
          wrData[MIN_LSB +: DATA_W] = rdData[LAST_LSB +: DATA_W];
          wrData[MAXTS_LSB +: TS_W] = timeStamp;
          wrData[MINTS_LSB +: TS_W] = timeStamp;
        end
        if (chIdxFf == LAST_CH) begin
          nxt_state = ST_QDONE;
        end else begin
          nxt_chIdx = chIdxFf + CH_W'(1);
          nxt_state = ST_QSCAN;
        end
      end
      ST_QDONE: begin
        nxt_respDone = 1'b1;
        nxt_state    = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_scanReady = (nxt_state == ST_IDLE);
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      stateFf             <= ST_IDLE;
      hasDataFf           <= '0;
      smpChanFf           <= '0;
      smpDataFf           <= '0;
      smpTsFf             <= '0;
      chIdxFf             <= '0;
      cmdFf               <= CMD_READ_ALL;
      loFf                <= '0;
      hiFf                <= '0;
      cfgHoldFf           <= '0;
      fmtHoldFf           <= FMT_ENG;
      termHoldFf          <= 1'b0;
      scanReadyFf         <= 1'b0;
      qAckFf              <= 1'b0;
      recValidFf          <= 1'b0;
      recChanFf           <= '0;
      recMaxFf            <= '0;
      maximum_timestampFf <= '0;
      recMinFf            <= '0;
      minimum_timestampFf <= '0;
      recLastFf           <= '0;
      recOnlyLastFf       <= 1'b0;
      recTermFf           <= 1'b0;
      recFormatFf         <= FMT_ENG;
      respDoneFf          <= 1'b0;
    end else begin
      stateFf             <= nxt_state;
      hasDataFf           <= nxt_hasData;
      smpChanFf           <= nxt_smpChan;
      smpDataFf           <= nxt_smpData;
      smpTsFf             <= nxt_smpTs;
      chIdxFf             <= nxt_chIdx;
      cmdFf               <= nxt_cmd;
      loFf                <= nxt_lo;
      hiFf                <= nxt_hi;
      cfgHoldFf           <= nxt_cfgHold;
      fmtHoldFf           <= nxt_fmtHold;
      termHoldFf          <= nxt_termHold;
      scanReadyFf         <= nxt_scanReady;
      qAckFf              <= nxt_qAck;
      recValidFf          <= nxt_recValid;
      recChanFf           <= nxt_recChan;
      recMaxFf            <= nxt_recMax;
      maximum_timestampFf <= nxt_maxTs;
      recMinFf            <= nxt_recMin;
      minimum_timestampFf <= nxt_minTs;
      recLastFf           <= nxt_recLast;
      recOnlyLastFf       <= nxt_recOnlyLast;
      recTermFf           <= nxt_recTerm;
      recFormatFf         <= nxt_recFormat;
      respDoneFf          <= nxt_respDone;
    end
  end

  // checks
  logic [CH_W-1:0] prevChanFf;
  logic            inRespFf;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      prevChanFf <= '0;
      inRespFf   <= 1'b0;
    end else begin
      if (recValidFf) begin
        prevChanFf <= recChanFf;
      end
      inRespFf <= respDoneFf ? 1'b0 : (recValidFf ? 1'b1 : inRespFf);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  chk_scan_update: assert property (stateFf == ST_IDLE && scanTake && acqRun &&
      cfgMask[scanChan] |=> stateFf == ST_UPD && wrEn)
    else $error("accepted scan did not update its record");
  chk_unconf_skip: assert property (scanTake && !cfgMask[scanChan] |=> !wrEn)
    else $error("unconfigured channel was written");
  chk_reply_conf: assert property (recValidFf |-> $past(cfgHoldFf[chIdxFf]))
    else $error("reply for an unconfigured channel");
  chk_init_fresh: assert property (stateFf == ST_UPD && !hasDataFf[smpChanFf] |->
      wrData[MAX_LSB +: DATA_W] == smpDataFf && wrData[MINTS_LSB +: TS_W] == smpTsFf)
    else $error("first update after clear did not initialise");
  chk_max_grows: assert property (stateFf == ST_UPD && hasDataFf[smpChanFf] &&
      newD > oldMax |-> wrData[MAX_LSB +: DATA_W] == smpDataFf &&
      wrData[MAXTS_LSB +: TS_W] == smpTsFf)
    else $error("higher reading did not replace maximum");
  chk_readall_keep: assert property (stateFf == ST_QEMIT && cmdFf != CMD_READ_RESET
      |-> !wrEn)
    else $error("non-clearing query wrote the store");
  chk_reset_last: assert property (stateFf == ST_QEMIT && cmdFf == CMD_READ_RESET &&
      hasDataFf[chIdxFf] |-> wrEn && wrAddr == chIdxFf &&
      wrData[MAX_LSB +: DATA_W] == rdData[LAST_LSB +: DATA_W] &&
      wrData[MIN_LSB +: DATA_W] == rdData[LAST_LSB +: DATA_W] &&
      wrData[MINTS_LSB +: TS_W] == timeStamp)
    else $error("reset query did not set extremes to latest");
  chk_latest_only: assert property (recValidFf && recOnlyLastFf |->
      recMaxFf == '0 && recMinFf == '0)
    else $error("latest-only reply carried extremes");
  chk_sel_range: assert property (recValidFf && cmdFf == CMD_LATEST_SEL |->
      recChanFf >= loFf && recChanFf <= hiFf)
    else $error("selective reply outside the range");
  chk_scan_order: assert property (recValidFf && inRespFf |-> recChanFf > prevChanFf)
    else $error("records out of channel order");
  chk_cfg_clear: assert property (cfgLoad && stateFf != ST_UPD |=> hasDataFf == '0)
    else $error("new configuration did not clear extremes");
  chk_query_ends: assert property (qAckFf |-> ##[1:40] respDoneFf)
    else $error("response never ended");

  cov_update: cover property (stateFf == ST_UPD && hasDataFf[smpChanFf]);
  cov_reset_query: cover property (stateFf == ST_QEMIT && wrEn);
  cov_sel_reply: cover property (recValidFf && cmdFf == CMD_LATEST_SEL);
  cov_swap_fmt: cover property (recValidFf && recFormatFf == FMT_BIN_HL);
endmodule : channel_high_low_last_tracker

// ---- bench/host_query_model.sv ----
/*
  host controller model: issues one query at a time on the request port
  and waits for the accept pulse and the end of the response.
  assumes the tracker samples its query inputs on the rising edge of mclk.
*/
`timescale 1ns/10ps
module host_query_model (
  // clock
  input  wire logic                         mclk,
  // device answers
  input  wire logic                         qAckFf,
  input  wire logic                         respDoneFf,
  // query request
  output logic                              qValid,
  output logic [1:0]                        qCmd,
  output logic [tracker_pkg::CH_W-1:0]      qLo,
  output logic [tracker_pkg::CH_W-1:0]      qHi
);
  import tracker_pkg::*;

  initial begin
    qValid = 1'b0;
    qCmd   = 2'h0;
    qLo    = 4'h0;
    qHi    = 4'h0;
  end

  // request held until the accept pulse is seen or 40 cycles pass, then released
  task automatic ask(input logic [1:0] cmd, input logic [CH_W-1:0] lo,
                     input logic [CH_W-1:0] hi, output bit ok);
    int k;
    @(negedge mclk);
    qValid = 1'b1;
    qCmd   = cmd;
    qLo    = lo;
    qHi    = hi;
    k = 0;
    while (qAckFf !== 1'b1 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    ok = (k < 40);
    // released lines carry the inverse so stale values cannot pass
    qValid = 1'b0;
    qCmd   = ~cmd;
    qLo    = ~lo;
    qHi    = ~hi;
    k = 0;
    while (respDoneFf !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    ok = ok && (k < 100);
  endtask : ask
endmodule : host_query_model

// ---- bench/channel_high_low_last_tracker_test.sv ----
/*
  self-checking bench for the extreme/latest tracker: drives scans and
  queries, keeps its own per-channel model and compares every record.
  assumes the host model in host_query_model.sv.
*/
`timescale 1ns/10ps
module channel_high_low_last_tracker_test;
  import tracker_pkg::*;
  typedef struct packed {
    logic [3:0] ch; logic [15:0] mx; logic [31:0] mxt; logic [15:0] mn;
    logic [31:0] mnt; logic [15:0] la; logic only; logic term; logic [1:0] fmt;
  } rec_s;
  logic        mclk, rst_n, cfgLoad, acqRun, termEnable, scanValid;
  logic [15:0] cfgMask, scanData, recMaxFf, recMinFf, recLastFf;
  logic [31:0] timeStamp, maximum_timestampFf, minimum_timestampFf;
  logic [3:0]  scanChan, qLo, qHi, recChanFf;
  logic [1:0]  fmtCode, qCmd, recFormatFf;
  logic        scanReadyFf, qValid, qAckFf, recValidFf, recOnlyLastFf, recTermFf, respDoneFf;
  int          n_errors, n_checks;
  logic signed [15:0] hiV[16], loV[16], laV[16];
  logic [31:0] hiT[16], loT[16];
  bit          has[16];
  rec_s        expQ[$], gotQ[$];

  channel_high_low_last_tracker channel_high_low_last_tracker_i (
    .mclk(mclk), .rst_n(rst_n), .cfgMask(cfgMask), .cfgLoad(cfgLoad), .acqRun(acqRun),
    .fmtCode(fmtCode), .termEnable(termEnable), .timeStamp(timeStamp),
    .scanValid(scanValid), .scanChan(scanChan), .scanData(scanData),
    .scanReadyFf(scanReadyFf), .qValid(qValid), .qCmd(qCmd), .qLo(qLo), .qHi(qHi),
    .qAckFf(qAckFf), .recValidFf(recValidFf), .recChanFf(recChanFf), .recMaxFf(recMaxFf),
    .maximum_timestampFf(maximum_timestampFf), .recMinFf(recMinFf),
    .minimum_timestampFf(minimum_timestampFf), .recLastFf(recLastFf),
    .recOnlyLastFf(recOnlyLastFf), .recTermFf(recTermFf), .recFormatFf(recFormatFf),
    .respDoneFf(respDoneFf));
  host_query_model host_query_model_i (
    .mclk(mclk), .qAckFf(qAckFf), .respDoneFf(respDoneFf),
    .qValid(qValid), .qCmd(qCmd), .qLo(qLo), .qHi(qHi));

  always #5 mclk = ~mclk;

  always @(negedge mclk) begin
    if (recValidFf === 1'b1) begin
      gotQ.push_back({recChanFf, recMaxFf, maximum_timestampFf, recMinFf,
                      minimum_timestampFf, recLastFf, recOnlyLastFf, recTermFf, recFormatFf});
    end
  end

  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_rec(input rec_s got, input rec_s exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t record ch %0d got %h exp %h", $time, exp.ch, got, exp);
    end
  endtask : chk_rec

  task automatic chk_count(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t record count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_count

  function automatic logic [15:0] fmtd(input logic [15:0] v, input logic [1:0] f);
    return (f == FMT_BIN_HL) ? {v[7:0], v[15:8]} : v;
  endfunction : fmtd

  task automatic new_cfg(input logic [15:0] m);
    @(negedge mclk);
    cfgMask = m;
    cfgLoad = 1'b1;
    @(negedge mclk);
    cfgLoad = 1'b0;
    foreach (has[c]) has[c] = 1'b0;
  endtask : new_cfg

  task automatic scan(input logic [3:0] ch, input logic [15:0] d);
    int k;
    @(negedge mclk);
    timeStamp = timeStamp + 32'h0000_0101;
    scanValid = 1'b1;
    scanChan  = ch;
    scanData  = d;
    k = 0;
    while (scanReadyFf !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 20) begin
      n_errors++;
      $display("[ERR] %0t scan not accepted", $time);
    end
    if (acqRun && cfgMask[ch]) begin
      laV[ch] = d;
      if (!has[ch] || $signed(d) > hiV[ch]) {hiV[ch], hiT[ch]} = {d, timeStamp};
      if (!has[ch] || $signed(d) < loV[ch]) {loV[ch], loT[ch]} = {d, timeStamp};
      has[ch] = 1'b1;
    end
    @(negedge mclk);
    scanValid = 1'b0;
    scanData  = ~d;
  endtask : scan

  task automatic query(input logic [1:0] cmd, input logic [3:0] lo, input logic [3:0] hi,
                       input logic [1:0] f, input logic term);
    bit   ok;
    rec_s r;
    fmtCode    = f;
    termEnable = term;
    for (int c = 0; c < 16; c++) begin
      if (cfgMask[c] && (cmd != CMD_LATEST_SEL || (c >= lo && c <= hi))) begin
        r.only = (cmd == CMD_LATEST_ALL || cmd == CMD_LATEST_SEL);
        r.ch   = c[3:0];
        r.mx   = r.only ? 16'h0 : fmtd(hiV[c], f);
        r.mxt  = r.only ? 32'h0 : hiT[c];
        r.mn   = r.only ? 16'h0 : fmtd(loV[c], f);
        r.mnt  = r.only ? 32'h0 : loT[c];
        r.la   = fmtd(laV[c], f);
        r.term = term;
        r.fmt  = f;
        expQ.push_back(r);
      end
    end
    host_query_model_i.ask(cmd, lo, hi, ok);
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t query not acknowledged or not finished", $time);
    end
    chk_count(gotQ.size(), expQ.size());
    for (int i = 0; i < expQ.size() && i < gotQ.size(); i++) chk_rec(gotQ[i], expQ[i]);
    if (cmd == CMD_READ_RESET) begin
      for (int c = 0; c < 16; c++) begin
        if (cfgMask[c] && has[c]) begin
          {hiV[c], loV[c], hiT[c], loT[c]} = {laV[c], laV[c], timeStamp, timeStamp};
        end
      end
    end
    expQ.delete();
    gotQ.delete();
  endtask : query

  initial begin
    #200000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    {mclk, rst_n, cfgLoad, acqRun, termEnable, scanValid} = 6'h0;
    {cfgMask, scanData, timeStamp, scanChan, fmtCode} = '0;
    void'($urandom(32'ha77003d0));
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    new_cfg(16'h8403);
    acqRun = 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 16; c++) begin
        // extremes of the signed range on channel 1
        if (c == 1 && p == 1) scan(4'h1, 16'h7fff);
        else if (c == 1 && p == 2) scan(4'h1, 16'h8000);
        else scan(c[3:0], 16'($urandom));
      end
    end
    acqRun = 1'b0;
    scan(4'h0, 16'h7fff);
    acqRun = 1'b1;
    query(CMD_READ_ALL, 4'h0, 4'h0, FMT_ENG, 1'b1);
    query(CMD_READ_ALL, 4'h0, 4'h0, FMT_ENG, 1'b0);
    query(CMD_READ_RESET, 4'h0, 4'h0, FMT_BIN_LH, 1'b0);
    query(CMD_READ_ALL, 4'h0, 4'h0, FMT_BIN_HL, 1'b1);
    for (int c = 0; c < 16; c++) scan(c[3:0], 16'($urandom));
    query(CMD_LATEST_ALL, 4'h0, 4'h0, FMT_COUNTS, 1'b1);
    query(CMD_LATEST_SEL, 4'h1, 4'ha, FMT_ENG, 1'b0);
    query(CMD_LATEST_SEL, 4'hf, 4'hf, FMT_BIN_HL, 1'b1);
    new_cfg(16'h0403);
    for (int c = 0; c < 16; c++) scan(c[3:0], 16'h0010 + 16'(c));
    query(CMD_READ_ALL, 4'h0, 4'h0, FMT_ENG, 1'b1);
    wrap_up();
  end
endmodule : channel_high_low_last_tracker_test
